//--- design/rspm_top.sv
// Strobe qualification, timing outputs and shared-pin mux of the card
`timescale 1ns/10ps
module rspm_top
    import rspm_pkg::*;
(
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    // Setup, taken on i_cfg_wr
    input  wire logic                 i_cfg_wr,
    input  wire logic [RATE_W-1:0]    i_cfg_serial_rate0,
    input  wire logic [RATE_W-1:0]    i_cfg_serial_rate1,
    input  wire logic [RATE_W-1:0]    i_cfg_serial_rate2,
    input  wire logic                 i_cfg_third_serial_en,
    input  wire logic                 i_cfg_can_en,
    input  wire logic [CAN_SEL_W-1:0] i_cfg_can_rate,
    input  wire logic                 i_cfg_first_mark_en,
    input  wire logic                 i_cfg_second_mark_en,
    input  wire logic                 i_cfg_first_mark_high,
    input  wire logic                 i_cfg_second_mark_high,
    input  wire logic                 i_cfg_event_out_en,
    input  wire logic                 i_cfg_vf_high,
    input  wire logic [CNT_W-1:0]     i_cfg_vf_period,
    input  wire logic [CNT_W-1:0]     i_cfg_vf_width,
    input  wire logic                 i_cfg_tp_high,
    input  wire logic [CNT_W-1:0]     i_cfg_tp_period,
    input  wire logic [CNT_W-1:0]     i_cfg_tp_width,
    // Receiver core
    input  wire logic                 i_gnss_epoch,
    input  wire logic                 i_position_valid,
    input  wire logic                 i_third_serial_transmit,
    input  wire logic                 i_first_can_transmit,
    // First mark pin
    input  wire logic                 i_first_mark_input,
    output logic                      o_first_mark_pin,
    output logic                      o_first_mark_pin_oe_n,
    // Second mark pin
    input  wire logic                 i_second_mark_input,
    output logic                      o_second_mark_pin,
    output logic                      o_second_mark_pin_oe_n,
    // Frequency pin
    input  wire logic                 i_vf_pin,
    output logic                      o_variable_frequency_out,
    output logic                      o_vf_pin_oe_n,
    // Other strobes
    input  wire logic                 i_card_reset_n,
    output logic                      o_timing_pulse_out,
    output logic                      o_position_valid_out,
    // Status towards the core
    output logic [SDIV_W-1:0]         o_serial_div0,
    output logic [SDIV_W-1:0]         o_serial_div1,
    output logic [SDIV_W-1:0]         o_serial_div2,
    output logic [CDIV_W-1:0]         o_can_div,
    output logic                      o_third_serial_en,
    output logic                      o_can_en,
    output logic                      o_first_mark_event,
    output logic                      o_second_mark_event,
    output logic                      o_card_reset_req,
    output logic                      o_first_can_receive
);

    // Setup registers
    logic [SDIV_W-1:0] sdiv_q [SER_NUM];
    logic [CDIV_W-1:0] cdiv_q;
    logic              third_en_q;
    logic              can_en_q;
    logic              m1_en_q;
    logic              m2_en_q;
    logic              m1_high_q;
    logic              m2_high_q;
    logic              evout_en_q;
    logic              vf_high_q;
    logic [CNT_W-1:0]  vf_period_q;
    logic [CNT_W-1:0]  vf_width_q;
    logic              tp_high_q;
    logic [CNT_W-1:0]  tp_period_q;
    logic [CNT_W-1:0]  tp_width_q;

    // Pin side registers
    logic              m1_pin_q;
    logic              m2_pin_q;
    logic              vf_oe_n_q;
    logic              crx_s1_q;
    logic              crx_s2_q;
    logic              crx_q;
    logic              pos_q;

    // Decoded setup
    logic [RATE_W-1:0] rsel [SER_NUM];
    wire               can_ok;
    wire               m1_live;
    wire               m2_live;
    wire               vf_on;
    wire               vf_pulse;
    wire               tp_pulse;

    assign rsel[0] = i_cfg_serial_rate0;
    assign rsel[1] = i_cfg_serial_rate1;
    assign rsel[2] = i_cfg_serial_rate2;
    assign can_ok  = (i_cfg_can_rate <= CAN_SEL_MAX);

    // A shared pin belongs to one function at a time
    assign m1_live = m1_en_q && !third_en_q;
    assign m2_live = m2_en_q && !can_en_q;
    // The host is expected to turn the event output off first;
    // CAN still wins here so a missed step cannot cause contention
    assign vf_on   = evout_en_q && !can_en_q;

    // Rate selects out of range leave the old rate in place
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < SER_NUM; i++) begin
            if (!i_nrst) begin
                sdiv_q[i] <= rspm_baud_div(RATE_SEL_RST);
            end else if (i_cfg_wr && rsel[i] <= RATE_SEL_MAX) begin
                sdiv_q[i] <= rspm_baud_div(rsel[i]);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cdiv_q <= rspm_can_div(CAN_SEL_RST);
        end else if (i_cfg_wr && can_ok) begin
            cdiv_q <= rspm_can_div(i_cfg_can_rate);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            third_en_q  <= THIRD_SER_EN_RST;
            can_en_q    <= CAN_EN_RST;
            m1_en_q     <= MARK_EN_RST;
            m2_en_q     <= MARK_EN_RST;
            m1_high_q   <= ACT_HIGH_RST;
            m2_high_q   <= ACT_HIGH_RST;
            evout_en_q  <= EVOUT_EN_RST;
            vf_high_q   <= ACT_HIGH_RST;
            vf_period_q <= VF_PERIOD_RST;
            vf_width_q  <= VF_WIDTH_RST;
            tp_high_q   <= ACT_HIGH_RST;
            tp_period_q <= TP_PERIOD_RST;
            tp_width_q  <= TP_WIDTH_RST;
        end else if (i_cfg_wr) begin
            third_en_q  <= i_cfg_third_serial_en;
            can_en_q    <= i_cfg_can_en;
            m1_en_q     <= i_cfg_first_mark_en;
            m2_en_q     <= i_cfg_second_mark_en;
            m1_high_q   <= i_cfg_first_mark_high;
            m2_high_q   <= i_cfg_second_mark_high;
            evout_en_q  <= i_cfg_event_out_en;
            vf_high_q   <= i_cfg_vf_high;
            vf_period_q <= i_cfg_vf_period;
            vf_width_q  <= i_cfg_vf_width;
            tp_high_q   <= i_cfg_tp_high;
            tp_period_q <= i_cfg_tp_period;
            tp_width_q  <= i_cfg_tp_width;
        end
    end

    // Mark inputs, qualified at the minimum pulse width
    rspm_sync_qual #(
        .QUAL          (MARK_QUAL_CYC)
    ) u_first_mark (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_pin         (i_first_mark_input),
        .i_active_high (m1_high_q),
        .i_enable      (m1_live),
        .o_level       (),
        .o_event       (o_first_mark_event)
    );

    rspm_sync_qual #(
        .QUAL          (MARK_QUAL_CYC)
    ) u_second_mark (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_pin         (i_second_mark_input),
        .i_active_high (m2_high_q),
        .i_enable      (m2_live),
        .o_level       (),
        .o_event       (o_second_mark_event)
    );

    // Card reset pin; level request lasts while the pin stays low
    rspm_sync_qual #(
        .QUAL          (RST_QUAL_CYC)
    ) u_card_reset (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_pin         (i_card_reset_n),
        .i_active_high (1'b0),
        .i_enable      (1'b1),
        .o_level       (o_card_reset_req),
        .o_event       ()
    );

    // Timing pulse restarts on each computed time epoch
    rspm_pulse_gen u_timing_pulse (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_enable      (1'b1),
        .i_active_high (tp_high_q),
        .i_period      (tp_period_q),
        .i_width       (tp_width_q),
        .i_sync        (i_gnss_epoch),
        .o_pulse       (tp_pulse)
    );

    // Frequency output; period one cycle holds a steady level, period two gives half the clock rate
    rspm_pulse_gen u_var_freq (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_enable      (vf_on),
        .i_active_high (vf_high_q),
        .i_period      (vf_period_q),
        .i_width       (vf_width_q),
        .i_sync        (1'b0),
        .o_pulse       (vf_pulse)
    );

    // Pin drivers and the CAN receive synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            m1_pin_q  <= PIN_IDLE;
            m2_pin_q  <= PIN_IDLE;
            vf_oe_n_q <= 1'b0;
            crx_s1_q  <= PIN_IDLE;
            crx_s2_q  <= PIN_IDLE;
            crx_q     <= PIN_IDLE;
            pos_q     <= 1'b0;
        end else begin
            m1_pin_q  <= i_third_serial_transmit;
            m2_pin_q  <= i_first_can_transmit;
            vf_oe_n_q <= !vf_on;
            crx_s1_q  <= i_vf_pin;
            crx_s2_q  <= crx_s1_q;
            crx_q     <= can_en_q ? crx_s2_q : PIN_IDLE;
            pos_q     <= i_position_valid;
        end
    end

    // Pin enables are low while this end drives
    assign o_first_mark_pin         = m1_pin_q;
    assign o_first_mark_pin_oe_n    = !third_en_q;
    assign o_second_mark_pin        = m2_pin_q;
    assign o_second_mark_pin_oe_n   = !can_en_q;
    assign o_variable_frequency_out = vf_pulse;
    assign o_vf_pin_oe_n            = vf_oe_n_q;
    assign o_timing_pulse_out       = tp_pulse;
    assign o_position_valid_out     = pos_q;
    assign o_serial_div0            = sdiv_q[0];
    assign o_serial_div1            = sdiv_q[1];
    assign o_serial_div2            = sdiv_q[2];
    assign o_can_div                = cdiv_q;
    assign o_third_serial_en        = third_en_q;
    assign o_can_en                 = can_en_q;
    assign o_first_can_receive      = crx_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    wire m1_act = (i_first_mark_input == m1_high_q);
    wire m2_act = (i_second_mark_input == m2_high_q);

    sequence rate_bad_s;
        i_cfg_wr && (i_cfg_serial_rate0 > RATE_SEL_MAX);
    endsequence

    rate_keep_a: assert property (
        rate_bad_s |=> $stable(o_serial_div0))
        else $error("Invalid serial rate was taken");
    rate_take_a: assert property (
        (i_cfg_wr && i_cfg_serial_rate1 <= RATE_SEL_MAX) |=>
            o_serial_div1 == rspm_baud_div($past(i_cfg_serial_rate1)))
        else $error("Serial rate not applied");
    can_rate_a: assert property (
        o_can_div == rspm_can_div(2'h0) || o_can_div == rspm_can_div(2'h1)
        || o_can_div == rspm_can_div(2'h2))
        else $error("CAN divider outside offered rates");
    third_reset_a: assert property (
        $rose(i_nrst) |-> !o_third_serial_en && o_first_mark_pin_oe_n)
        else $error("Third serial port active after reset");
    first_mark_off_a: assert property (
        (third_en_q && $past(third_en_q)) |-> !o_first_mark_event)
        else $error("First mark event while serial owns pin");
    second_mark_off_a: assert property (
        (can_en_q && $past(can_en_q)) |-> !o_second_mark_event)
        else $error("Second mark event while CAN owns pin");
    first_mark_wide_a: assert property (
        o_first_mark_event |-> $past(m1_act, 3) && $past(m1_act, 10))
        else $error("First mark event without qualifying width");
    second_mark_wide_a: assert property (
        o_second_mark_event |-> $past(m2_act, 3) && $past(m2_act, 10))
        else $error("Second mark event without qualifying width");
    vf_release_a: assert property (
        can_en_q |=> o_vf_pin_oe_n)
        else $error("Frequency pin driven while CAN enabled");
    can_rx_path_a: assert property (
        $past(can_en_q) |-> o_first_can_receive == $past(i_vf_pin, 3))
        else $error("CAN receive not routed from shared pin");
    pos_valid_a: assert property (
        ##1 o_position_valid_out == $past(i_position_valid))
        else $error("Position valid output not following");
    reset_req_a: assert property (
        $rose(o_card_reset_req) |->
            !$past(i_card_reset_n, 3) && !$past(i_card_reset_n, 300))
        else $error("Card reset taken on a short pulse");

endmodule : rspm_top

//--- design/rspm_pkg.sv
// Constants, reset values and rate tables of the strobe and pin mux block
package rspm_pkg;

    // Clock
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 20;

    // Qualifying widths, rounded up to whole cycles
    localparam int unsigned MARK_MIN_NS   = 150;
    localparam int unsigned MARK_QUAL_CYC =
        (MARK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_MIN_US    = 20;
    localparam int unsigned RST_QUAL_CYC  =
        (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned QUAL_W        = 10;

    // Serial rates
    localparam int unsigned BAUD_NUM = 9;
    localparam int unsigned BAUD_TABLE [BAUD_NUM] = '{
        2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400, 460800};
    localparam int unsigned SER_NUM     = 3;
    localparam int unsigned RATE_W      = 4;
    localparam int unsigned SDIV_W      = 16;
    localparam logic [RATE_W-1:0] RATE_SEL_RST = 4'h2;
    localparam logic [RATE_W-1:0] RATE_SEL_MAX = 4'h8;

    // CAN rates
    localparam int unsigned CAN_NUM = 3;
    localparam int unsigned CAN_KBPS [CAN_NUM] = '{250, 500, 1000};
    localparam int unsigned CAN_SEL_W   = 2;
    localparam int unsigned CDIV_W      = 8;
    localparam logic [CAN_SEL_W-1:0] CAN_SEL_RST = 2'h0;
    localparam logic [CAN_SEL_W-1:0] CAN_SEL_MAX = 2'h2;

    // Pulse generators
    localparam int unsigned CNT_W = 26;
    localparam logic [CNT_W-1:0] TP_PERIOD_RST = 26'(CLK_HZ);
    localparam logic [CNT_W-1:0] TP_WIDTH_RST  = 26'(CLK_HZ / 1000);
    localparam logic [CNT_W-1:0] VF_PERIOD_RST = 26'h0000000;
    localparam logic [CNT_W-1:0] VF_WIDTH_RST  = 26'h0000000;

    // Reset values of control bits
    localparam logic THIRD_SER_EN_RST = 1'b0;
    localparam logic CAN_EN_RST       = 1'b0;
    localparam logic MARK_EN_RST      = 1'b1;
    localparam logic ACT_HIGH_RST     = 1'b0;
    localparam logic EVOUT_EN_RST     = 1'b1;
    localparam logic PIN_IDLE         = 1'b1;

    function automatic logic [SDIV_W-1:0] rspm_baud_div(
        input logic [RATE_W-1:0] sel);
        rspm_baud_div = SDIV_W'(CLK_HZ / BAUD_TABLE[sel]);
    endfunction : rspm_baud_div

    function automatic logic [CDIV_W-1:0] rspm_can_div(
        input logic [CAN_SEL_W-1:0] sel);
        rspm_can_div = CDIV_W'(CLK_HZ / (CAN_KBPS[sel] * 1000));
    endfunction : rspm_can_div

endpackage : rspm_pkg

//--- design/rspm_sync_qual.sv
// Two-flop synchroniser with asserted-width qualification and event pulse
`timescale 1ns/10ps
module rspm_sync_qual
    import rspm_pkg::*;
#(
    parameter int unsigned QUAL = MARK_QUAL_CYC
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_nrst,
    // Pin and setup
    input  wire logic i_pin,
    input  wire logic i_active_high,
    input  wire logic i_enable,
    // Qualified result
    output logic      o_level,
    output logic      o_event
);
    localparam logic [QUAL_W-1:0] QUAL_C  = QUAL_W'(QUAL);
    localparam logic [QUAL_W-1:0] QUAL_M1 = QUAL_W'(QUAL - 1);

    logic              s1_q;
    logic              s2_q;
    logic [QUAL_W-1:0] cnt_q;
    logic [QUAL_W-1:0] cnt_d;
    logic              ev_q;
    logic              ev_d;
    wire               act;

    // Only the second flop is looked at; glitches reset the count
    assign act   = i_enable && (s2_q == i_active_high);
    assign cnt_d = !act ? '0 :
                   (cnt_q == QUAL_C) ? cnt_q : cnt_q + 1'b1;
    assign ev_d  = act && (cnt_q == QUAL_M1);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s1_q  <= PIN_IDLE;
            s2_q  <= PIN_IDLE;
            cnt_q <= '0;
            ev_q  <= 1'b0;
        end else begin
            s1_q  <= i_pin;
            s2_q  <= s1_q;
            cnt_q <= cnt_d;
            ev_q  <= ev_d;
        end
    end

    assign o_level = (cnt_q == QUAL_C);
    assign o_event = ev_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    event_single_a: assert property (
        o_event |-> o_level ##1 !o_event)
        else $error("Qualified event longer than one cycle");
    event_level_a: assert property (
        o_event |-> o_level && !$past(o_level))
        else $error("Event without fresh qualified level");

endmodule : rspm_sync_qual

//--- design/rspm_pulse_gen.sv
// Programmable period, width and polarity pulse generator
`timescale 1ns/10ps
module rspm_pulse_gen
    import rspm_pkg::*;
(
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // Setup
    input  wire logic             i_enable,
    input  wire logic             i_active_high,
    input  wire logic [CNT_W-1:0] i_period,
    input  wire logic [CNT_W-1:0] i_width,
    // Restart of the period
    input  wire logic             i_sync,
    // Pulse
    output logic                  o_pulse
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             pulse_q;
    wire              run;
    wire              wrap;
    wire              act;

    // A zero period stops the output at its inactive level
    assign run   = i_enable && (i_period != '0);
    assign wrap  = (cnt_q >= i_period - 1'b1);
    assign cnt_d = (!run || i_sync || wrap) ? '0 : cnt_q + 1'b1;
    assign act   = run && (cnt_d < i_width);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt_q   <= '0;
            pulse_q <= PIN_IDLE;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= act ? i_active_high : !i_active_high;
        end
    end

    assign o_pulse = pulse_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sync_edge_a: assert property (
        (run && i_sync && i_width != '0) |=> o_pulse == $past(i_active_high))
        else $error("Pulse not asserted on the time edge");
    idle_level_a: assert property (
        !run |=> o_pulse == !$past(i_active_high))
        else $error("Stopped generator not at inactive level");

endmodule : rspm_pulse_gen

//--- dv/rspm_host_model.sv
// Host-side model of the mark, card reset and CAN receive lines
`timescale 1ns/10ps
module rspm_host_model (
    // Lines driven by the host
    output logic o_first_mark_channel,
    output logic o_second_mark_channel,
    output logic o_rst_n,
    output logic o_can_rx
);
    // Lines idle high, where their pull-ups leave them
    initial begin
        o_first_mark_channel = 1'h1;
        o_second_mark_channel = 1'h1;
        o_rst_n = 1'h1;
        o_can_rx = 1'h1;
    end

    task automatic drive(input int sel, input logic lvl);
        case (sel)
            1: o_first_mark_channel = lvl;
            2: o_second_mark_channel = lvl;
            3: o_rst_n = lvl;
            default: o_can_rx = lvl;
        endcase
    endtask : drive

    // Width in ns; the bench picks widths on both sides of the limits
    task automatic pulse(input int sel, input logic lvl, input int ns);
        drive(sel, lvl);
        #(ns);
        drive(sel, ~lvl);
    endtask : pulse
endmodule : rspm_host_model

//--- dv/tb_top.sv
// Self-checking bench of the strobe and shared-pin block
`timescale 1ns/10ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
    err_total++; $display("MISMATCH %0t %s", $time, m); end end
module tb_top import rspm_pkg::*; ;
    logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, ep = 1'h0, pv = 1'h0;
    logic stx = 1'h1, ctx = 1'h1, tse = 1'h0, cen = 1'h0, m1e = 1'h1;
    logic m2e = 1'h1, m1h = 1'h0, m2h = 1'h0, evo = 1'h1;
    logic vfh = 1'h0, tph = 1'h0;
    logic [RATE_W-1:0] rt = RATE_SEL_RST;
    logic [CAN_SEL_W-1:0] cr = CAN_SEL_RST;
    logic [CNT_W-1:0] vfp = VF_PERIOD_RST, vfw = VF_WIDTH_RST;
    logic [CNT_W-1:0] tpp = TP_PERIOD_RST, tpw = TP_WIDTH_RST;
    logic fmp, fmo, smp, smo, vf, vfo, tp, pvo, ev1, ev2, rq, crx, tso, ceo;
    logic h1, h2, hrst_n, hrx;
    logic [SDIV_W-1:0] d0, d1, d2;
    logic [CDIV_W-1:0] cd;
    int err_total = 0, num_checks = 0, n1 = 0, n2 = 0, nr = 0;
    // Shared pins: the device wins while its enable is low
    wire p1 = fmo ? h1 : fmp;
    wire p2 = smo ? h2 : smp;
    wire p3 = vfo ? hrx : vf;

    rspm_top rspm_top_inst (.i_clk(clk), .i_nrst(nrst), .i_cfg_wr(wr),
        .i_cfg_serial_rate0(rt), .i_cfg_serial_rate1(rt),
        .i_cfg_serial_rate2(rt), .i_cfg_third_serial_en(tse),
        .i_cfg_can_en(cen), .i_cfg_can_rate(cr), .i_cfg_first_mark_en(m1e),
        .i_cfg_second_mark_en(m2e), .i_cfg_first_mark_high(m1h),
        .i_cfg_second_mark_high(m2h), .i_cfg_event_out_en(evo),
        .i_cfg_vf_high(vfh), .i_cfg_vf_period(vfp), .i_cfg_vf_width(vfw),
        .i_cfg_tp_high(tph), .i_cfg_tp_period(tpp), .i_cfg_tp_width(tpw),
        .i_gnss_epoch(ep), .i_position_valid(pv),
        .i_third_serial_transmit(stx), .i_first_can_transmit(ctx),
        .i_first_mark_input(p1), .o_first_mark_pin(fmp),
        .o_first_mark_pin_oe_n(fmo), .i_second_mark_input(p2),
        .o_second_mark_pin(smp), .o_second_mark_pin_oe_n(smo),
        .i_vf_pin(p3), .o_variable_frequency_out(vf), .o_vf_pin_oe_n(vfo),
        .i_card_reset_n(hrst_n), .o_timing_pulse_out(tp),
        .o_position_valid_out(pvo), .o_serial_div0(d0), .o_serial_div1(d1),
        .o_serial_div2(d2), .o_can_div(cd), .o_third_serial_en(tso),
        .o_can_en(ceo), .o_first_mark_event(ev1),
        .o_second_mark_event(ev2), .o_card_reset_req(rq),
        .o_first_can_receive(crx));
    rspm_host_model rspm_host_model_inst (.o_first_mark_channel(h1), .o_second_mark_channel(h2),
        .o_rst_n(hrst_n), .o_can_rx(hrx));
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        if (ev1 === 1'h1) n1++;
        if (ev2 === 1'h1) n2++;
        if (rq === 1'h1) nr++;
    end

    // Setup write; waits out the extra cycle of the pin enable
    task automatic cfg();
        @(negedge clk) wr = 1'h1;
        @(negedge clk) wr = 1'h0;
        repeat (2) @(negedge clk);
    endtask : cfg

    task automatic t_reset();
        `CHK(d0, 16'(CLK_HZ / 9600), "div0")
        `CHK(d1, 16'(CLK_HZ / 9600), "div1")
        `CHK(cd, 8'(CLK_HZ / 250000), "can div")
        `CHK({tso, fmo, ceo, smo}, 4'h5, "mux state")
        `CHK({vfo, vf, tp, pvo}, 4'h6, "outputs")
        $display("reset values done");
    endtask : t_reset

    task automatic t_rates();
        logic [SDIV_W-1:0] e;
        logic [CDIV_W-1:0] c;
        e = 16'(CLK_HZ / 9600);
        c = 8'(CLK_HZ / 250000);
        // Index 9 and CAN index 3 must leave the old rate
        for (int i = 0; i < 10; i++) begin
            rt = 4'(i);
            cr = 2'(i % 4);
            cfg();
            if (i < 9) e = 16'(CLK_HZ / BAUD_TABLE[i]);
            if (i % 4 < 3) c = 8'(CLK_HZ / (CAN_KBPS[i % 4] * 1000));
            `CHK(d2, e, "serial div")
            `CHK({d0, d1}, {e, e}, "serial div 0 1")
            `CHK(cd, c, "can div")
        end
        $display("rates done");
    endtask : t_rates

    task automatic t_marks();
        int s;
        s = n1;
        rspm_host_model_inst.pulse(1, 1'h0, 160);
        repeat (14) @(negedge clk);
        `CHK(n1, s + 1, "mark 160 ns")
        rspm_host_model_inst.pulse(1, 1'h0, 140);
        repeat (14) @(negedge clk);
        `CHK(n1, s + 1, "mark 140 ns")
        // Line low first so the new polarity starts inactive
        rspm_host_model_inst.drive(2, 1'h0);
        m2h = 1'h1;
        cfg();
        repeat (12) @(negedge clk);
        s = n2;
        rspm_host_model_inst.pulse(2, 1'h1, 400);
        repeat (14) @(negedge clk);
        `CHK(n2, s + 1, "long high mark")
        $display("marks done");
    endtask : t_marks

    task automatic t_mux();
        int s1, s2;
        s1 = n1;
        s2 = n2;
        m2h = 1'h0;
        rspm_host_model_inst.drive(2, 1'h1);
        tse = 1'h1;
        cen = 1'h1;
        cfg();  // Marks and frequency output left on on purpose
        s2 = n2;
        `CHK({fmo, smo, vfo, tso, ceo}, 5'h07, "pin owners")
        stx = 1'h0;
        ctx = 1'h0;
        rspm_host_model_inst.drive(4, 1'h0);
        repeat (14) @(negedge clk);
        `CHK({fmp, smp, crx}, 3'h0, "pins follow")
        `CHK(n1, s1, "mark 1 ignored")
        `CHK(n2, s2, "mark 2 ignored")
        stx = 1'h1;
        ctx = 1'h1;
        rspm_host_model_inst.drive(4, 1'h1);
        repeat (4) @(negedge clk);
        `CHK(crx, 1'h1, "can receive")
        tse = 1'h0;
        cen = 1'h0;
        cfg();
        `CHK({fmo, smo, vfo, tso, ceo}, 5'h18, "pins back")
        $display("mux done");
    endtask : t_mux

    task automatic t_outputs();
        int k;
        tph = 1'h1;
        tpp = 26'h0000014;
        tpw = 26'h0000003;
        vfh = 1'h1;
        vfp = 26'h000000A;
        vfw = 26'h0000005;
        cfg();
        ep = 1'h1;
        pv = 1'h1;
        @(negedge clk);
        ep = 1'h0;
        `CHK(pvo, 1'h1, "position valid")
        // Pulse stands from the edge after the epoch for width cycles
        for (int i = 0; i < 4; i++) begin
            `CHK(tp, i < 3, "timing pulse")
            @(negedge clk);
        end
        k = 0;
        repeat (20) begin
            @(negedge clk);
            k += (vf === 1'h1);
        end
        `CHK(k, 10, "frequency duty")
        $display("outputs done");
    endtask : t_outputs

    task automatic t_card_reset();
        int s;
        s = nr;
        rspm_host_model_inst.pulse(3, 1'h0, 18000);
        repeat (5) @(negedge clk);
        `CHK(nr, s, "short reset")
        rspm_host_model_inst.pulse(3, 1'h0, 22000);
        repeat (5) @(negedge clk);
        `CHK({nr > s, rq}, 2'h2, "reset request")
        $display("card reset done");
    endtask : t_card_reset

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (10) @(negedge clk);
        t_reset();
        nrst = 1'h1;
        t_rates();
        t_marks();
        t_mux();
        t_outputs();
        t_card_reset();
        tally_and_finish();
    end
    // The tests need some 2200 cycles; allow about nine times that
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
